// [rtl/mmd_bus_if.sv]
`timescale 1ns/1ps
// Internal MMD access port towards the MMD register spaces
interface mmd_bus_if;
	logic [4:0] dev;
	logic [15:0] index;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	modport master (output dev, output index, output wdata, output wr, output rd, input rdata);
	modport slave (input dev, input index, input wdata, input wr, input rd, output rdata);
endinterface

// [rtl/mmd_space.sv]
`timescale 1ns/1ps
// Small MMD register store: 32 devices x 16 words each, index low bits used
module mmd_space (
	input wire logic clock,
	input wire logic rst,
	mmd_bus_if.slave bus
);
	import phy_regs_pkg::*;
	typedef struct packed {
		logic [15:0] rdata;
	} state_type;
	logic [15:0] mem [0:511];
	state_type state_reg;
	state_type state_next;
	logic [8:0] addr;
	assign addr = {bus.dev, bus.index[3:0]};
	assign bus.rdata = mem[addr];
	// Storage has no reset; contents are undefined until written
	always_ff @(posedge clock) begin
		if (bus.wr) begin
			mem[addr] <= bus.wdata;
		end
	end
	// Unused holder state kept to follow the register idiom
	always_comb begin
		state_next = state_reg;
		state_next.rdata = mem[addr];
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule

// [rtl/phy_nextpage_mmd_loopback_regs.sv]
// Overview of operation
// - Bit 15 of the partner next-page register shows whether more next pages follow.
// - Bit 14 of the partner next-page register is read-only and reports a received link word.
// - Bits 13, 12 and 10:0 report page type, partner ability to act and message field.
// - Bit 11 reads 1 when the previous transmitted link code word bit was zero.
// - Setup bits 15:14 reset to 00 and select the data register use, 00 meaning index access.
// - Code 01 accesses data without changing the held index.
// - Code 10 advances the index after each data read and write.
// - Code 11 advances the index after data writes only.
// - Setup bits 4:0 hold the device address, bits 13:5 reserved, all reset zero.
// - With code 00 the data register reads and writes the held index.
// - With nonzero codes the data register moves the addressed data word, resetting to zero; the MMD store here has no reset.
// - Loopback bit 8 set returns line receive data to the same port, clear is normal.
// - In loopback the transmit pair carries exactly what the receive pair brings.
// - The local transmit toggle reports 1 when the previous transmitted bit was one.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module phy_nextpage_mmd_loopback_regs (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [15:0] rx_page_word [4],
	input wire logic [3:0] rx_page_valid,
	input wire logic [3:0] tx_prev_bit,
	output logic [3:0] local_tx_toggle,
	input wire logic [3:0] line_rx_p,
	input wire logic [3:0] line_rx_n,
	input wire logic [3:0] fabric_tx_p,
	input wire logic [3:0] fabric_tx_n,
	output logic [3:0] line_tx_p,
	output logic [3:0] line_tx_n,
	output logic [3:0] loopback_active
);
	import phy_regs_pkg::*;

	typedef struct packed {
		logic [3:0][15:0] partner_np;
		logic [3:0] partner_ack;
		logic [3:0][15:0] setup;
		logic [3:0][15:0] index;
		logic [3:0][15:0] loopback;
		logic [3:0] prev_tx;
		logic [15:0] rdata;
		logic [3:0] local_toggle;
		logic [3:0] tx_p;
		logic [3:0] tx_n;
		logic [3:0] lb_out;
		logic [3:0] rx_p_s1;
		logic [3:0] rx_p_s2;
		logic [3:0] rx_n_s1;
		logic [3:0] rx_n_s2;
		logic [3:0] prev_s1;
		logic [3:0] prev_s2;
	} state_type;

	state_type state_reg;
	state_type state_next;
	mmd_bus_if mmd ();
	logic [2:0] port_dec;
	logic [1:0] port_sel;
	logic port_ok;
	logic data_hit;
	logic [11:0] ofs;
	mmd_op_type op_sel;

	// Port nibble 1..4 maps to index 0..3; other nibbles hit nothing
	function automatic logic [2:0] port_decode(input logic [3:0] nib);
		if (nib >= 4'h1 && nib <= 4'h4) begin
			port_decode = {1'b1, 2'(nib - 4'h1)};
		end else begin
			port_decode = 3'h0;
		end
	endfunction

	assign port_dec = port_decode(addr[15:12]);
	assign port_ok = port_dec[2];
	assign port_sel = port_dec[1:0];
	assign ofs = addr[11:0];
	assign data_hit = port_ok && ofs == `OFS_MMD_DATA;
	assign op_sel = mmd_op_type'(state_reg.setup[port_sel][`MMD_OP_HI:`MMD_OP_LO]);

	// Indirect MMD path, only active for data codes
	assign mmd.dev = state_reg.setup[port_sel][`MMD_DEV_HI:`MMD_DEV_LO];
	assign mmd.index = state_reg.index[port_sel];
	assign mmd.wdata = wdata;
	assign mmd.wr = wr && data_hit && op_sel != op_register;
	assign mmd.rd = rd && data_hit && op_sel != op_register;

	mmd_space u_mmd (
		.clock(clock),
		.rst(rst),
		.bus(mmd)
	);

	// Next state: captures, register writes, read mux and loopback path
	always_comb begin
		state_next = state_reg;
		state_next.rdata = 16'h0000;
		state_next.rx_p_s1 = line_rx_p;
		state_next.rx_p_s2 = state_reg.rx_p_s1;
		state_next.rx_n_s1 = line_rx_n;
		state_next.rx_n_s2 = state_reg.rx_n_s1;
		state_next.prev_s1 = tx_prev_bit;
		state_next.prev_s2 = state_reg.prev_s1;
		for (int p = 0; p < `PORT_COUNT; p++) begin
			// Capture the partner page word when the receiver marks it good
			if (rx_page_valid[p]) begin
				state_next.partner_np[p] = rx_page_word[p];
				state_next.partner_ack[p] = 1'b1;
			end
			state_next.prev_tx[p] = state_reg.prev_s2[p];
			state_next.local_toggle[p] = state_reg.prev_s2[p];
			state_next.lb_out[p] = state_reg.loopback[p][`LB_ENABLE_BIT];
			// Loopback bypasses the fabric; synchronised line data costs two cycles
			if (state_reg.loopback[p][`LB_ENABLE_BIT]) begin
				state_next.tx_p[p] = state_reg.rx_p_s2[p];
				state_next.tx_n[p] = state_reg.rx_n_s2[p];
			end else begin
				state_next.tx_p[p] = fabric_tx_p[p];
				state_next.tx_n[p] = fabric_tx_n[p];
			end
		end
		// Register writes
		if (wr && port_ok) begin
			if (ofs == `OFS_MMD_SETUP) begin
				state_next.setup[port_sel] = wdata;
			end else if (ofs == `OFS_MMD_DATA) begin
				if (op_sel == op_register) begin
					state_next.index[port_sel] = wdata;
				end else if (op_sel == op_data_inc_rw || op_sel == op_data_inc_wr) begin
					state_next.index[port_sel] = state_reg.index[port_sel] + 16'h0001;
				end
			end else if (ofs == `OFS_LOOPBACK) begin
				state_next.loopback[port_sel] = wdata & `LOOPBACK_WRITE_MASK;
			end
		end
		// Register reads; answer stands in the following cycle
		if (rd && port_ok) begin
			if (ofs == `OFS_PARTNER_NP) begin
				state_next.rdata = {state_reg.partner_np[port_sel][15], state_reg.partner_ack[port_sel],
					state_reg.partner_np[port_sel][13:0]};
			end else if (ofs == `OFS_MMD_SETUP) begin
				state_next.rdata = state_reg.setup[port_sel];
			end else if (ofs == `OFS_MMD_DATA) begin
				if (op_sel == op_register) begin
					state_next.rdata = state_reg.index[port_sel];
				end else begin
					state_next.rdata = mmd.rdata;
				end
				if (op_sel == op_data_inc_rw) begin
					state_next.index[port_sel] = state_reg.index[port_sel] + 16'h0001;
				end
			end else if (ofs == `OFS_LOOPBACK) begin
				state_next.rdata = state_reg.loopback[port_sel];
				state_next.loopback[port_sel][`LB_CLR_ON_READ_BIT] = 1'b0;
			end
		end
	end

	// All state in one register; reset values are constants only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			for (int p = 0; p < `PORT_COUNT; p++) begin
				state_reg.setup[p] <= `MMD_SETUP_RESET;
				state_reg.index[p] <= `MMD_DATA_RESET;
				state_reg.loopback[p] <= `LOOPBACK_RESET;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata = state_reg.rdata;
	assign local_tx_toggle = state_reg.local_toggle;
	assign line_tx_p = state_reg.tx_p;
	assign line_tx_n = state_reg.tx_n;
	assign loopback_active = state_reg.lb_out;

	// Assertions
	property p_ack_on_capture;
		@(posedge clock) disable iff (rst) rx_page_valid[0] |=> state_reg.partner_ack[0];
	endproperty
	a_ack_on_capture: assert property (p_ack_on_capture) else $error("ack not set after page");

	property p_np_read;
		@(posedge clock) disable iff (rst) (rd && addr == 16'h1110)
			|=> rdata == $past({state_reg.partner_np[0][15], state_reg.partner_ack[0],
			state_reg.partner_np[0][13:0]});
	endproperty
	a_np_read: assert property (p_np_read) else $error("partner page read wrong");

	property p_capture_word;
		@(posedge clock) disable iff (rst) rx_page_valid[1]
			|=> state_reg.partner_np[1] == $past(rx_page_word[1]);
	endproperty
	a_capture_word: assert property (p_capture_word) else $error("page not captured");

	property p_ack_sticky;
		@(posedge clock) disable iff (rst) state_reg.partner_ack[1]
			|=> state_reg.partner_ack[1];
	endproperty
	a_ack_sticky: assert property (p_ack_sticky) else $error("receipt flag dropped");

	property p_ack_read;
		@(posedge clock) disable iff (rst) (rd && addr == 16'h2110)
			|=> rdata[`NP_ACK_BIT] == $past(state_reg.partner_ack[1]);
	endproperty
	a_ack_read: assert property (p_ack_read) else $error("receipt flag read wrong");

	property p_toggle_read;
		@(posedge clock) disable iff (rst) (rd && addr == 16'h2110)
			|=> rdata[`NP_TOGGLE_BIT] == $past(state_reg.partner_np[1][`NP_TOGGLE_BIT]);
	endproperty
	a_toggle_read: assert property (p_toggle_read) else $error("partner toggle read wrong");

	// Software writes must never disturb the captured page word
	property p_np_write_ignored;
		@(posedge clock) disable iff (rst) (wr && addr == 16'h2110 && !rx_page_valid[1])
			|=> state_reg.partner_np[1] == $past(state_reg.partner_np[1]);
	endproperty
	a_np_write_ignored: assert property (p_np_write_ignored) else $error("page word written");

	// Indirect access; the port is the one addressed in the strobe cycle
	property p_setup_write;
		@(posedge clock) disable iff (rst) (wr && port_ok && ofs == `OFS_MMD_SETUP)
			|=> state_reg.setup[$past(port_sel)] == $past(wdata);
	endproperty
	a_setup_write: assert property (p_setup_write) else $error("setup not stored");

	property p_setup_read;
		@(posedge clock) disable iff (rst) (rd && port_ok && ofs == `OFS_MMD_SETUP)
			|=> rdata == $past(state_reg.setup[port_sel]);
	endproperty
	a_setup_read: assert property (p_setup_read) else $error("setup read wrong");

	property p_op_hold;
		@(posedge clock) disable iff (rst) (data_hit && (wr || rd) && op_sel == op_data_hold)
			|=> state_reg.index[$past(port_sel)] == $past(state_reg.index[port_sel]);
	endproperty
	a_op_hold: assert property (p_op_hold) else $error("index moved in hold mode");

	property p_inc_rw;
		@(posedge clock) disable iff (rst) (data_hit && (wr || rd) && op_sel == op_data_inc_rw)
			|=> state_reg.index[$past(port_sel)] == $past(state_reg.index[port_sel]) + 16'h0001;
	endproperty
	a_inc_rw: assert property (p_inc_rw) else $error("index not advanced");

	property p_inc_wr_only;
		@(posedge clock) disable iff (rst) (data_hit && rd && op_sel == op_data_inc_wr)
			|=> state_reg.index[$past(port_sel)] == $past(state_reg.index[port_sel]);
	endproperty
	a_inc_wr_only: assert property (p_inc_wr_only) else $error("read advanced index");

	property p_inc_wr_write;
		@(posedge clock) disable iff (rst) (data_hit && wr && op_sel == op_data_inc_wr)
			|=> state_reg.index[$past(port_sel)] == $past(state_reg.index[port_sel]) + 16'h0001;
	endproperty
	a_inc_wr_write: assert property (p_inc_wr_write) else $error("write left index");

	property p_index_write;
		@(posedge clock) disable iff (rst) (data_hit && wr && op_sel == op_register)
			|=> state_reg.index[$past(port_sel)] == $past(wdata);
	endproperty
	a_index_write: assert property (p_index_write) else $error("index not stored");

	property p_index_read;
		@(posedge clock) disable iff (rst) (rd && data_hit && op_sel == op_register)
			|=> rdata == $past(state_reg.index[port_sel]);
	endproperty
	a_index_read: assert property (p_index_read) else $error("index read wrong");

	property p_data_read;
		@(posedge clock) disable iff (rst) (data_hit && rd && op_sel != op_register)
			|=> rdata == $past(mmd.rdata);
	endproperty
	a_data_read: assert property (p_data_read) else $error("data word read wrong");

	// Loopback control and transmit path
	property p_lb_active;
		@(posedge clock) disable iff (rst) 1'b1
			|=> loopback_active[0] == $past(state_reg.loopback[0][`LB_ENABLE_BIT]);
	endproperty
	a_lb_active: assert property (p_lb_active) else $error("loopback flag wrong");

	property p_fabric_path;
		@(posedge clock) disable iff (rst) !state_reg.loopback[0][`LB_ENABLE_BIT]
			|=> line_tx_p[0] == $past(fabric_tx_p[0]);
	endproperty
	a_fabric_path: assert property (p_fabric_path) else $error("fabric data lost");

	property p_loop_path;
		@(posedge clock) disable iff (rst) state_reg.loopback[0][`LB_ENABLE_BIT] ##0 $stable(state_reg.loopback[0])
			|=> line_tx_p[0] == $past(state_reg.rx_p_s2[0]);
	endproperty
	a_loop_path: assert property (p_loop_path) else $error("loopback data mismatch");

	property p_loop_path_n;
		@(posedge clock) disable iff (rst) state_reg.loopback[0][`LB_ENABLE_BIT] ##0 $stable(state_reg.loopback[0])
			|=> line_tx_n[0] == $past(state_reg.rx_n_s2[0]);
	endproperty
	a_loop_path_n: assert property (p_loop_path_n) else $error("loopback n data mismatch");

	property p_lb_write;
		@(posedge clock) disable iff (rst) (wr && addr == 16'h1122)
			|=> state_reg.loopback[0] == ($past(wdata) & `LOOPBACK_WRITE_MASK);
	endproperty
	a_lb_write: assert property (p_lb_write) else $error("loopback write wrong");

	property p_clear_on_read;
		@(posedge clock) disable iff (rst) (rd && addr == 16'h1122) |=> !state_reg.loopback[0][`LB_CLR_ON_READ_BIT];
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("bit 1 not cleared");

	// A read clears bit 1 only; the other bits keep their value
	property p_clear_keep;
		@(posedge clock) disable iff (rst) (rd && addr == 16'h1122)
			|=> state_reg.loopback[0][15:2] == $past(state_reg.loopback[0][15:2]);
	endproperty
	a_clear_keep: assert property (p_clear_keep) else $error("read changed loopback");

	property p_bit0_zero;
		@(posedge clock) disable iff (rst) !state_reg.loopback[0][0] && !state_reg.loopback[1][0]
			&& !state_reg.loopback[2][0] && !state_reg.loopback[3][0];
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("read-only zero bit set");

	// Local toggle follows the synchronised previous bit
	property p_toggle_sync;
		@(posedge clock) disable iff (rst) 1'b1
			|=> local_tx_toggle == $past(state_reg.prev_s2);
	endproperty
	a_toggle_sync: assert property (p_toggle_sync) else $error("local toggle wrong");

	c_loop: cover property (@(posedge clock) disable iff (rst) loopback_active[0]);
	c_inc: cover property (@(posedge clock) disable iff (rst) wr && op_sel == op_data_inc_rw && ofs == `OFS_MMD_DATA);
	c_page: cover property (@(posedge clock) disable iff (rst) rx_page_valid[0] ##1 rd && addr == 16'h1110);
	c_hold: cover property (@(posedge clock) disable iff (rst) data_hit && rd && op_sel == op_data_hold);
	c_clear: cover property (@(posedge clock) disable iff (rst) rd && addr == 16'h1122 && state_reg.loopback[0][1]);
endmodule

// [rtl/phy_regs_map.svh]
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH
// Per-port byte offsets; the port number fills address bits 15:12
`define OFS_PARTNER_NP 12'h110
`define OFS_MMD_SETUP 12'h11A
`define OFS_MMD_DATA 12'h11C
`define OFS_LOOPBACK 12'h122
// Field positions
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11
`define MMD_OP_HI 15
`define MMD_OP_LO 14
`define MMD_DEV_HI 4
`define MMD_DEV_LO 0
`define LB_ENABLE_BIT 8
`define LB_CLR_ON_READ_BIT 1
// Reset values, loopback write mask and port count
`define MMD_SETUP_RESET 16'h0000
`define MMD_DATA_RESET 16'h0000
`define LOOPBACK_RESET 16'h00F4
`define LOOPBACK_WRITE_MASK 16'hFFFE
`define PORT_COUNT 4
`endif

// [rtl/phy_regs_pkg.sv]
package phy_regs_pkg;
	typedef enum logic [1:0] {
		op_register,
		op_data_hold,
		op_data_inc_rw,
		op_data_inc_wr
	} mmd_op_type;
	typedef logic [15:0] word_type;
endpackage

// [sim/link_partner_model.sv]
`timescale 1ns/1ps
// Far-end partner: line levels change every cycle, next pages arrive on request
module link_partner_model (
	input wire logic clock,
	input wire logic [3:0] page_req,
	input wire logic [15:0] page_word,
	output logic [15:0] rx_page_word [4],
	output logic [3:0] rx_page_valid,
	output logic [3:0] line_rx_p,
	output logic [3:0] line_rx_n
);
	initial begin
		rx_page_word = '{default: 16'h0000};
		rx_page_valid = 4'h0;
		line_rx_p = 4'h0;
		line_rx_n = 4'hF;
	end
	// A page word is only good during its pulse, so it is scrambled afterwards
	always @(posedge clock) begin
		line_rx_p <= line_rx_p + 4'h7;
		line_rx_n <= ~(line_rx_p + 4'h7);
		rx_page_valid <= page_req;
		for (int k = 0; k < 4; k++) begin
			rx_page_word[k] <= page_req[k] ? page_word : ~rx_page_word[k];
		end
	end
endmodule

// [sim/phy_nextpage_mmd_loopback_regs_bench.sv]
`timescale 1ns/1ps
`include "phy_regs_map.svh"
`define CHECK(g, e) compare(g, e)
module phy_nextpage_mmd_loopback_regs_bench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [15:0] rx_page_word [4];
	logic [3:0] rx_page_valid;
	logic [3:0] tx_prev_bit = 4'h0;
	logic [3:0] local_tx_toggle;
	logic [3:0] line_rx_p;
	logic [3:0] line_rx_n;
	logic [3:0] fabric_tx_p = 4'h0;
	logic [3:0] fabric_tx_n = 4'hF;
	logic [3:0] line_tx_p;
	logic [3:0] line_tx_n;
	logic [3:0] loopback_active;
	logic [3:0] page_req = 4'h0;
	logic [15:0] page_word = 16'h0000;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	phy_nextpage_mmd_loopback_regs phy_nextpage_mmd_loopback_regs_i (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_page_word(rx_page_word),
		.rx_page_valid(rx_page_valid), .tx_prev_bit(tx_prev_bit), .local_tx_toggle(local_tx_toggle),
		.line_rx_p(line_rx_p), .line_rx_n(line_rx_n), .fabric_tx_p(fabric_tx_p), .fabric_tx_n(fabric_tx_n),
		.line_tx_p(line_tx_p), .line_tx_n(line_tx_n), .loopback_active(loopback_active));
	link_partner_model link_partner_model_i (.clock(clock), .page_req(page_req), .page_word(page_word),
		.rx_page_word(rx_page_word), .rx_page_valid(rx_page_valid), .line_rx_p(line_rx_p), .line_rx_n(line_rx_n));

	always #25 clock = ~clock;

	// Whole run is about a hundred cycles; a hang is cut well after that
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			results();
		end
	end

	task results;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task compare(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task bus_write(input logic [3:0] port, input logic [11:0] ofs, input logic [15:0] d);
		@(posedge clock);
		addr <= {port, ofs};
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task expect_read(input logic [3:0] port, input logic [11:0] ofs, input logic [15:0] e);
		@(posedge clock);
		addr <= {port, ofs};
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		`CHECK(rdata, e);
	endtask

	task send_page(input logic [3:0] mask, input logic [15:0] w);
		@(posedge clock);
		page_word <= w;
		page_req <= mask;
		@(posedge clock);
		page_req <= 4'h0;
		repeat (2) @(posedge clock);
	endtask

	task check_reset;
		expect_read(4'h1, `OFS_MMD_SETUP, 16'h0000);
		expect_read(4'h4, `OFS_MMD_DATA, 16'h0000);
		expect_read(4'h3, `OFS_LOOPBACK, 16'h00F4);
		expect_read(4'h5, `OFS_LOOPBACK, 16'h0000);
		expect_read(4'h1, 12'h124, 16'h0000);
		expect_read(4'h1, `OFS_PARTNER_NP, 16'h0000);
		`CHECK(loopback_active, 4'h0);
	endtask

	task check_next_page;
		send_page(4'h2, 16'hA8C5);
		expect_read(4'h2, `OFS_PARTNER_NP, 16'hE8C5);
		send_page(4'h2, 16'h1234);
		bus_write(4'h2, `OFS_PARTNER_NP, 16'hFFFF);
		expect_read(4'h2, `OFS_PARTNER_NP, 16'h5234);
		@(posedge clock);
		tx_prev_bit <= 4'h5;
		repeat (4) @(posedge clock);
		`CHECK(local_tx_toggle, 4'h5);
		tx_prev_bit <= 4'hA;
		repeat (4) @(posedge clock);
		`CHECK(local_tx_toggle, 4'hA);
	endtask

	// Index first with code 00, then data codes, as management software does
	task check_mmd;
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h0003);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h0004);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h8003);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h1111);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h2222);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h0003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h0006);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h0004);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'hC003);
		expect_read(4'h3, `OFS_MMD_SETUP, 16'hC003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h1111);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h1111);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h3333);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h4003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h2222);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h2222);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h0003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h0005);
		bus_write(4'h3, `OFS_MMD_DATA, 16'h0004);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h8003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h3333);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h2222);
		bus_write(4'h3, `OFS_MMD_SETUP, 16'h0003);
		expect_read(4'h3, `OFS_MMD_DATA, 16'h0006);
	endtask

	task check_loopback;
		logic [3:0] hp [8];
		logic [3:0] hn [8];
		bus_write(4'h1, `OFS_LOOPBACK, 16'h01F7);
		expect_read(4'h1, `OFS_LOOPBACK, 16'h01F6);
		expect_read(4'h1, `OFS_LOOPBACK, 16'h01F4);
		`CHECK(loopback_active, 4'h1);
		// Port 1 echoes the line three clocks late, the others carry fabric data one clock late
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			fabric_tx_p <= 4'(i);
			fabric_tx_n <= ~4'(i);
			@(negedge clock);
			hp[i] = line_rx_p;
			hn[i] = line_rx_n;
			if (i >= 3) begin
				`CHECK(line_tx_p[0], hp[i-3][0]);
				`CHECK(line_tx_n[0], hn[i-3][0]);
			end
			if (i >= 1) begin
				`CHECK(line_tx_p[3:1], 3'(4'(i - 1) >> 1));
			end
		end
		bus_write(4'h1, `OFS_LOOPBACK, 16'h00F4);
		repeat (3) @(posedge clock);
		@(negedge clock);
		`CHECK(loopback_active, 4'h0);
		`CHECK(line_tx_n, fabric_tx_n);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		check_reset();
		check_next_page();
		check_mmd();
		check_loopback();
		results();
	end
endmodule
